/* File: design/iwd_defs.svh */
// Purpose: Constants for the instruction word decoder and its cycle timing
// Assumes: 16-bit program words, one core clock per oscillator period
// Notes: Offsets are word indices on the plain register port
//
// Functional notes
// RULE1: Base set of 75, extension of 8
// RULE2: Single word is 16 bits, opcode plus operands
// RULE3: Four double-word instructions, 32 bits total
// RULE4: Second word alone executes as no_operation
// RULE5: One cycle; two when taken or jumping
// RULE6: Double-word instructions take two cycles
// RULE7: Taken double-word branch takes three cycles
// RULE8: Instruction cycle is four oscillator periods
// RULE9: Byte ops decode file, destination, access bits
// RULE10: Destination zero accumulator, one file register
// RULE11: Bit ops decode file, bit number, access
// RULE12: Literal ops decode value and pointer select
// RULE13: Control ops decode address, call, table modes
// RULE14: Access bit zero fixed bank, one banked
// RULE15: Fast mode bit uses shadow registers
// RULE16: Table mode: keep, post-inc, post-dec, pre-inc
// RULE17: File field 8 bits or pointer selector
// RULE18: Inserted no_operation cycles suppress all writes
`ifndef IWD_DEFS_SVH
`define IWD_DEFS_SVH

`define IWD_BASE_COUNT 8'h4B
`define IWD_EXT_COUNT 8'h08
`define IWD_OSC_PER_CYC 4

`define IWD_REG_CTRL 4'h0
`define IWD_REG_STATUS 4'h1
`define IWD_REG_CYCLES 4'h2
`define IWD_REG_INSTRS 4'h3
`define IWD_REG_INFO 4'h4
`define IWD_REG_WORDS 4'h5
`define IWD_CTRL_RUN 0
`define IWD_CTRL_EXT 1
`define IWD_CTRL_RST 2'h1

`define IWD_F_DEST 9
`define IWD_F_ACC 8
`define IWD_F_FAST 0

`define IWD_OP_SECOND 4'hF
`define IWD_OP_MOVFF 4'hC
`define IWD_OP_BRA 4'hD
`define IWD_OP_BRCC 5'h1C
`define IWD_OP_GOTO 8'hEF
`define IWD_OP_CALL 7'h76
`define IWD_OP_LFSR 10'h3B8
`define IWD_OP_MOVSX 8'hEB
`define IWD_OP_EXT 6'h3A
`define IWD_OP_LIT 5'h01
`define IWD_OP_RETLW 3'h4
`define IWD_OP_CTRL 8'h00
`define IWD_OP_MOVLB 8'h01
`define IWD_OP_RET 7'h09
`define IWD_OP_RETFIE 7'h08
`define IWD_OP_CALLW 8'h14

`endif

/* File: design/iwd_pkg.sv */
// Purpose: Types shared by the decoder modules
// Assumes: Constants come from iwd_defs.svh
// Notes: Field struct is the decoded view of one program word
package iwd_pkg;
    typedef enum logic [2:0] {
        IWD_CLS_NOP, IWD_CLS_BYTE, IWD_CLS_BIT, IWD_CLS_LIT, IWD_CLS_CTRL, IWD_CLS_DW, IWD_CLS_EXT
    } iwd_class_t;

    typedef enum logic [1:0] {IWD_ST_EXEC, IWD_ST_SECOND, IWD_ST_FLUSH} iwd_state_t;

    typedef struct packed {
        iwd_class_t cls;
        logic [7:0] file_addr;
        logic dest_file;
        logic banked;
        logic [2:0] bit_num;
        logic [7:0] literal;
        logic [1:0] ptr_sel;
        logic fast;
        logic tbl;
        logic [1:0] tbl_mode;
        logic [10:0] offset;
        logic dword;
        logic pc_change;
        logic cond;
        logic writes_acc;
        logic writes_file;
        logic ext;
    } iwd_fields_t;
endpackage

/* File: design/iwd_dec_if.sv */
// Purpose: Carries a program word to the field decoder and its fields back
// Assumes: Decoder is purely combinational
// Notes: None
`timescale 1ns/1ns
interface iwd_dec_if;
    logic [15:0] word;
    logic ext_en;
    iwd_pkg::iwd_fields_t fld;
    modport dec (input word, input ext_en, output fld);
    modport user (output word, output ext_en, input fld);
endinterface

/* File: design/iwd_fields.sv */
// Purpose: Splits one 16-bit program word into its operand fields
// Assumes: Extension group decoded only when enabled
// Notes: Unknown MOVLB words and disabled MOVSX and extension-group words decode as no_operation; disabled CALLW decodes as control
`timescale 1ns/1ns
`include "iwd_defs.svh"
module iwd_fields (
    iwd_dec_if.dec dif
);
    logic [15:0] w;
    iwd_pkg::iwd_fields_t f;

    always_comb begin
        w = dif.word;
        f = '0;
        f.cls = iwd_pkg::IWD_CLS_NOP;
        // RULE9 RULE17 common operand fields
        f.file_addr = w[7:0];
        f.dest_file = w[`IWD_F_DEST];
        // RULE14 access bank select
        f.banked = w[`IWD_F_ACC];
        // RULE11 bit number field
        f.bit_num = w[11:9];
        // RULE12 literal value
        f.literal = w[7:0];
        f.ptr_sel = w[1:0];
        f.offset = w[10:0];
        // RULE4 orphan second word
        if (w[15:12] == `IWD_OP_SECOND) begin
            f.cls = iwd_pkg::IWD_CLS_NOP;
        // RULE3 double-word group
        end else if (w[15:12] == `IWD_OP_MOVFF) begin
            f.cls = iwd_pkg::IWD_CLS_DW;
            f.dword = 1'b1;
            f.writes_file = 1'b1;
        end else if (w[15:12] == `IWD_OP_BRA) begin
            f.cls = iwd_pkg::IWD_CLS_CTRL;
            f.pc_change = 1'b1;
        end else if (w[15:11] == `IWD_OP_BRCC) begin
            f.cls = iwd_pkg::IWD_CLS_CTRL;
            f.cond = 1'b1;
        end else if (w[15:8] == `IWD_OP_GOTO) begin
            f.cls = iwd_pkg::IWD_CLS_DW;
            f.dword = 1'b1;
            f.pc_change = 1'b1;
        end else if (w[15:9] == `IWD_OP_CALL) begin
            f.cls = iwd_pkg::IWD_CLS_DW;
            f.dword = 1'b1;
            f.pc_change = 1'b1;
            // RULE15 fast call
            f.fast = w[`IWD_F_ACC];
        end else if (w[15:6] == `IWD_OP_LFSR) begin
            f.cls = iwd_pkg::IWD_CLS_DW;
            f.dword = 1'b1;
            // RULE12 pointer register select
            f.ptr_sel = w[5:4];
        end else if (w[15:8] == `IWD_OP_MOVSX) begin
            // RULE1 extension gated
            f.cls = dif.ext_en ? iwd_pkg::IWD_CLS_DW : iwd_pkg::IWD_CLS_NOP;
            f.dword = dif.ext_en;
            f.ext = dif.ext_en;
        end else if (w[15:10] == `IWD_OP_EXT) begin
            f.cls = dif.ext_en ? iwd_pkg::IWD_CLS_EXT : iwd_pkg::IWD_CLS_NOP;
            f.ext = dif.ext_en;
        end else if (w[15:12] >= 4'h7) begin
            f.cls = iwd_pkg::IWD_CLS_BIT;
            f.cond = (w[15:13] == 3'h5);
            f.writes_file = (w[15:13] != 3'h5);
        end else if (w[15:11] == `IWD_OP_LIT) begin
            f.cls = iwd_pkg::IWD_CLS_LIT;
            f.pc_change = (w[10:8] == `IWD_OP_RETLW);
            f.writes_acc = (w[10:8] != `IWD_OP_RETLW);
        end else if (w[15:8] == `IWD_OP_CTRL) begin
            // RULE13 control operand fields
            f.cls = iwd_pkg::IWD_CLS_CTRL;
            // RULE16 table pointer mode
            f.tbl = (w[7:4] == 4'h0) && w[3];
            f.tbl_mode = f.tbl ? w[1:0] : 2'h0;
            f.pc_change = (w[7:1] == `IWD_OP_RET) || (w[7:1] == `IWD_OP_RETFIE)
                || (dif.ext_en && (w[7:0] == `IWD_OP_CALLW));
            f.fast = ((w[7:1] == `IWD_OP_RET) || (w[7:1] == `IWD_OP_RETFIE)) && w[`IWD_F_FAST];
            f.ext = dif.ext_en && (w[7:0] == `IWD_OP_CALLW);
        end else if (w[15:8] == `IWD_OP_MOVLB) begin
            f.cls = (w[7:4] == 4'h0) ? iwd_pkg::IWD_CLS_LIT : iwd_pkg::IWD_CLS_NOP;
        end else begin
            // RULE10 byte destination select
            f.cls = iwd_pkg::IWD_CLS_BYTE;
            if (w[15:12] == 4'h6) begin
                f.cond = !w[11];
                f.writes_file = w[11];
            end else if (w[15:9] != 7'h01) begin
                f.writes_acc = !w[`IWD_F_DEST];
                f.writes_file = w[`IWD_F_DEST];
                f.cond = (w[15:10] == 6'h0B) || (w[15:10] == 6'h0F) || (w[15:11] == 5'h09);
            end
        end
        dif.fld = f;
    end
endmodule // iwd_fields

/* File: design/iwd_qclk.sv */
// Purpose: Divides oscillator periods into instruction cycle strobes
// Assumes: Core clock is the oscillator
// Notes: Phase holds while stopped
`timescale 1ns/1ns
`include "iwd_defs.svh"
module iwd_qclk #(
    parameter int OSC_PER_CYC = `IWD_OSC_PER_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    output logic cyc_en_o,
    output logic [1:0] phase_o
);
    typedef struct packed {
        logic [1:0] phase;
        logic tick;
    } iwd_qclk_st_t;

    iwd_qclk_st_t q_reg;
    iwd_qclk_st_t q_next;

    // RULE8 four periods per cycle
    always_comb begin
        q_next = q_reg;
        q_next.tick = 1'b0;
        if (run_i) begin
            if (q_reg.phase == 2'(OSC_PER_CYC - 1)) begin
                q_next.phase = 2'h0;
                q_next.tick = 1'b1;
            end else begin
                q_next.phase = q_reg.phase + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign cyc_en_o = q_reg.tick;
    assign phase_o = q_reg.phase;
endmodule // iwd_qclk

/* File: design/iwd_core.sv */
// Purpose: Instruction word decode and instruction cycle timing
// Assumes: Program memory presents the next word by each cycle strobe
// Notes: Writes are steered per instruction cycle, never in flush cycles
`timescale 1ns/1ns
`include "iwd_defs.svh"
module iwd_core (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    input wire logic [15:0] INSTR_WORD_I,
    input wire logic COND_TRUE_I,
    output logic ADVANCE_O,
    output logic FLUSH_O,
    output logic [1:0] Q_PHASE_O,
    output logic [1:0] EXEC_STATE_O,
    output logic [2:0] CLASS_O,
    output logic [7:0] FILE_ADDR_O,
    output logic DEST_FILE_O,
    output logic BANKED_O,
    output logic [2:0] BIT_NUM_O,
    output logic [7:0] LITERAL_O,
    output logic [1:0] PTR_SEL_O,
    output logic FAST_MODE_O,
    output logic TBL_ACCESS_O,
    output logic [1:0] TBL_MODE_O,
    output logic [10:0] BRANCH_OFF_O,
    output logic [11:0] SECOND_OPND_O,
    output logic EXT_OP_O,
    output logic WR_ACC_O,
    output logic WR_FILE_O
);
    typedef struct packed {
        iwd_pkg::iwd_state_t st;
        iwd_pkg::iwd_fields_t ex;
        logic [15:0] first_word;
        logic [15:0] second_word;
        logic wr_acc;
        logic wr_file;
        logic [1:0] ctrl;
        logic [31:0] cycles;
        logic [31:0] instrs;
        logic [31:0] rdata;
    } iwd_core_st_t;

    iwd_core_st_t s_reg;
    iwd_core_st_t s_next;
    logic cyc_en;
    logic [1:0] phase;
    logic take_flush;
    iwd_dec_if dif ();

    iwd_qclk #(
        .OSC_PER_CYC(`IWD_OSC_PER_CYC)
    ) u_qclk (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .run_i(s_reg.ctrl[`IWD_CTRL_RUN]),
        .cyc_en_o(cyc_en),
        .phase_o(phase)
    );

    iwd_fields u_fields (
        .dif(dif)
    );

    assign dif.word = INSTR_WORD_I;
    assign dif.ext_en = s_reg.ctrl[`IWD_CTRL_EXT];

    // Register read view
    function automatic logic [31:0] read_mux(input logic [3:0] addr, input iwd_core_st_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            `IWD_REG_CTRL: v = {30'h0000_0000, s.ctrl};
            `IWD_REG_STATUS: v = {24'h00_0000, s.ex.dword, s.ex.cond, s.ex.pc_change, s.ex.cls, s.st};
            `IWD_REG_CYCLES: v = s.cycles;
            `IWD_REG_INSTRS: v = s.instrs;
            `IWD_REG_INFO: v = {16'h0000, `IWD_EXT_COUNT, `IWD_BASE_COUNT};
            `IWD_REG_WORDS: v = {s.first_word, s.second_word};
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Current instruction ends in a discarded cycle
    always_comb begin
        take_flush = 1'b0;
        case (s_reg.st)
            // RULE5 taken or jump
            iwd_pkg::IWD_ST_EXEC: begin
                take_flush = !s_reg.ex.dword && (s_reg.ex.pc_change || (s_reg.ex.cond && COND_TRUE_I));
            end
            // RULE7 taken double-word branch
            iwd_pkg::IWD_ST_SECOND: begin
                take_flush = s_reg.ex.pc_change;
            end
            default: take_flush = 1'b0;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 32'h0000_0000;
        if (REG_RD_I) begin
            s_next.rdata = read_mux(REG_ADDR_I, s_reg);
        end
        if (cyc_en) begin
            s_next.cycles = s_reg.cycles + 32'h0000_0001;
            s_next.wr_acc = 1'b0;
            s_next.wr_file = 1'b0;
            case (s_reg.st)
                iwd_pkg::IWD_ST_EXEC: begin
                    if (s_reg.ex.dword) begin
                        // RULE6 fetch second word
                        s_next.st = iwd_pkg::IWD_ST_SECOND;
                        s_next.second_word = INSTR_WORD_I;
                        s_next.wr_acc = s_reg.ex.writes_acc;
                        s_next.wr_file = s_reg.ex.writes_file;
                    end else if (take_flush) begin
                        // RULE18 flush writes nothing
                        s_next.st = iwd_pkg::IWD_ST_FLUSH;
                    end else begin
                        s_next.st = iwd_pkg::IWD_ST_EXEC;
                    end
                end
                iwd_pkg::IWD_ST_SECOND: begin
                    s_next.st = take_flush ? iwd_pkg::IWD_ST_FLUSH : iwd_pkg::IWD_ST_EXEC;
                end
                default: begin
                    s_next.st = iwd_pkg::IWD_ST_EXEC;
                end
            endcase
            if (s_next.st == iwd_pkg::IWD_ST_EXEC) begin
                // RULE2 load next word
                s_next.ex = dif.fld;
                s_next.first_word = INSTR_WORD_I;
                s_next.instrs = s_reg.instrs + 32'h0000_0001;
                // RULE10 single word write steering
                s_next.wr_acc = !dif.fld.dword && dif.fld.writes_acc;
                s_next.wr_file = !dif.fld.dword && dif.fld.writes_file;
            end
        end
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                `IWD_REG_CTRL: s_next.ctrl = REG_WDATA_I[1:0];
                `IWD_REG_CYCLES: s_next.cycles = 32'h0000_0000;
                `IWD_REG_INSTRS: s_next.instrs = 32'h0000_0000;
                default: s_next.ctrl = s_next.ctrl;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            s_reg <= '0;
            s_reg.st <= iwd_pkg::IWD_ST_FLUSH;
            s_reg.ctrl <= `IWD_CTRL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign REG_RDATA_O = s_reg.rdata;
    assign ADVANCE_O = cyc_en;
    assign FLUSH_O = cyc_en && take_flush;
    assign Q_PHASE_O = phase;
    assign EXEC_STATE_O = s_reg.st;
    assign CLASS_O = s_reg.ex.cls;
    assign FILE_ADDR_O = s_reg.ex.file_addr;
    assign DEST_FILE_O = s_reg.ex.dest_file;
    assign BANKED_O = s_reg.ex.banked;
    assign BIT_NUM_O = s_reg.ex.bit_num;
    assign LITERAL_O = s_reg.ex.literal;
    assign PTR_SEL_O = s_reg.ex.ptr_sel;
    assign FAST_MODE_O = s_reg.ex.fast;
    assign TBL_ACCESS_O = s_reg.ex.tbl;
    assign TBL_MODE_O = s_reg.ex.tbl_mode;
    assign BRANCH_OFF_O = s_reg.ex.offset;
    assign SECOND_OPND_O = s_reg.second_word[11:0];
    assign EXT_OP_O = s_reg.ex.ext;
    assign WR_ACC_O = s_reg.wr_acc;
    assign WR_FILE_O = s_reg.wr_file;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    sequence s_flush_hold;
        (s_reg.st == iwd_pkg::IWD_ST_FLUSH) [*4];
    endsequence

    sequence s_dw_taken;
        cyc_en && s_reg.st == iwd_pkg::IWD_ST_SECOND && s_reg.ex.pc_change;
    endsequence

    sequence s_quiet_three;
        !cyc_en [*3];
    endsequence

    a_cycle_four_clk: assert property (cyc_en |=> s_quiet_three) // RULE8
        else $error("instruction strobe closer than four clocks");

    a_cycle_period: assert property ((cyc_en && s_reg.ctrl[`IWD_CTRL_RUN]) ##1
        s_reg.ctrl[`IWD_CTRL_RUN] [*3] |=> cyc_en) // RULE8
        else $error("instruction strobe missing after four clocks");

    a_single_one_cycle: assert property ((cyc_en && s_reg.st == iwd_pkg::IWD_ST_EXEC && !s_reg.ex.dword
        && !s_reg.ex.pc_change && !(s_reg.ex.cond && COND_TRUE_I)) |=> s_reg.st == iwd_pkg::IWD_ST_EXEC) // RULE5
        else $error("plain single word did not finish in one cycle");

    a_taken_two_cycle: assert property ((cyc_en && s_reg.st == iwd_pkg::IWD_ST_EXEC && !s_reg.ex.dword
        && s_reg.ex.cond && COND_TRUE_I) |=> s_flush_hold) // RULE5
        else $error("true condition did not add a flush cycle");

    a_dword_second: assert property ((cyc_en && s_reg.st == iwd_pkg::IWD_ST_EXEC && s_reg.ex.dword)
        |=> s_reg.st == iwd_pkg::IWD_ST_SECOND && s_reg.second_word == $past(INSTR_WORD_I)) // RULE6
        else $error("double word did not take its second cycle");

    a_dword_long_branch: assert property (s_dw_taken |=> s_flush_hold) // RULE7
        else $error("taken double word branch lacks third cycle");

    a_flush_no_write: assert property (s_reg.st != iwd_pkg::IWD_ST_EXEC && s_reg.ex.dword == 1'b0
        |-> !WR_ACC_O && !WR_FILE_O) // RULE18
        else $error("write strobe during inserted cycle");

    a_orphan_word_nop: assert property ((INSTR_WORD_I[15:12] == `IWD_OP_SECOND)
        |-> dif.fld.cls == iwd_pkg::IWD_CLS_NOP && !dif.fld.writes_acc && !dif.fld.writes_file) // RULE4
        else $error("orphan second word not decoded as no_operation");

    a_dest_select: assert property ((s_reg.st == iwd_pkg::IWD_ST_EXEC && s_reg.ex.cls == iwd_pkg::IWD_CLS_BYTE
        && s_reg.first_word[15:12] != 4'h6
        && (WR_ACC_O || WR_FILE_O)) |-> WR_FILE_O == DEST_FILE_O && WR_ACC_O == !DEST_FILE_O) // RULE10
        else $error("result steered to wrong destination");

    a_bank_select: assert property ((dif.fld.cls == iwd_pkg::IWD_CLS_BYTE || dif.fld.cls == iwd_pkg::IWD_CLS_BIT)
        |-> dif.fld.banked == INSTR_WORD_I[`IWD_F_ACC] && dif.fld.file_addr == INSTR_WORD_I[7:0]) // RULE14
        else $error("access bank bit or file address misdecoded");

    a_read_one_cycle: assert property (REG_RD_I && REG_ADDR_I == `IWD_REG_INFO
        |=> REG_RDATA_O == {16'h0000, `IWD_EXT_COUNT, `IWD_BASE_COUNT} ##1 (REG_RD_I || REG_RDATA_O == 32'h0000_0000))
        else $error("read data not in the cycle after the strobe only");
endmodule // iwd_core

/* File: sim/iwd_prog_mem.sv */
// Purpose: Program memory model feeding words and condition results to the core
// Assumes: One word is taken on each advance pulse
// Notes: Shows a changing pattern for LAT cycles after each advance
`timescale 1ns/1ns
module iwd_prog_mem #(
    parameter int DEPTH = 64,
    parameter int LAT = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic advance_i,
    input wire logic [15:0] mem_i [DEPTH],
    input wire logic cond_i [DEPTH],
    output logic [15:0] word_o,
    output logic cond_o
);
    logic [5:0] ptr_reg;
    logic [1:0] wait_reg;
    logic [15:0] last_reg;
    logic last_cond_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ptr_reg <= 6'h00;
            wait_reg <= 2'h0;
            last_reg <= 16'h0000;
            last_cond_reg <= 1'h0;
        end else if (advance_i) begin
            ptr_reg <= ptr_reg + 6'h01;
            wait_reg <= LAT[1:0];
            last_reg <= word_o;
            last_cond_reg <= cond_o;
        end else if (wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end
    end
    // Slow answer: inverse of the old word until the new one settles
    assign word_o = (wait_reg != 2'h0) ? ~last_reg : mem_i[ptr_reg];
    assign cond_o = (wait_reg != 2'h0) ? ~last_cond_reg : cond_i[ptr_reg];
endmodule // iwd_prog_mem

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the decoder core
// Assumes: Codes hold {cond, state, class, writes, field kind} per word
// Notes: Registers checked after the program run
`timescale 1ns/1ns
`include "iwd_defs.svh"
module testbench;
    localparam int N = 34;
    localparam logic [15:0] WORDS [N] = '{
        16'h0E12, 16'h2655, 16'h2580, 16'h8B7F, 16'hD005, 16'h1234, 16'hEF10, 16'hF0A5, 16'h0000,
        16'hC123, 16'hF456, 16'hF789, 16'hE003, 16'h0000, 16'hE003, 16'h0E34, 16'h0013, 16'h0000,
        16'h0010, 16'h0000, 16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h000E,
        16'h000F, 16'hEE20, 16'hF012, 16'hE805, 16'h0E00, 16'hE805, 16'h0E01};
    localparam logic [15:0] CODES [N] = '{
        16'h0323, 16'h0111, 16'h0121, 16'h0212, 16'h0409, 16'h2000, 16'h0500, 16'h1006, 16'h2000,
        16'h0500, 16'h1016, 16'h0000, 16'h0400, 16'hA000, 16'h0400, 16'h0323, 16'h0404, 16'h2000,
        16'h0404, 16'h2000, 16'h0405, 16'h0405, 16'h0405, 16'h0405, 16'h0405, 16'h0405, 16'h0405,
        16'h0405, 16'h0507, 16'h1006, 16'h0000, 16'h0323, 16'h0608, 16'h0323};
    logic core_clk, rst_n, reg_wr, reg_rd, cond_true, advance, flush, dest_file, banked, fast_mode;
    logic tbl_access, ext_op, wr_acc, wr_file;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] instr_word;
    logic [1:0] q_phase, exec_state, ptr_sel, tbl_mode;
    logic [2:0] cls, bit_num;
    logic [7:0] file_addr, literal;
    logic [10:0] branch_off;
    logic [11:0] second_opnd;
    logic [15:0] prog [64];
    logic pcond [64];
    int errors, checked, cyc, last_adv, stop_cnt;

    iwd_prog_mem #(.DEPTH(64), .LAT(2)) PMEM (.clk_i(core_clk), .rst_n_i(rst_n), .advance_i(advance),
        .mem_i(prog), .cond_i(pcond), .word_o(instr_word), .cond_o(cond_true));
    iwd_core DUT (.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .INSTR_WORD_I(instr_word),
        .COND_TRUE_I(cond_true), .ADVANCE_O(advance), .FLUSH_O(flush), .Q_PHASE_O(q_phase),
        .EXEC_STATE_O(exec_state), .CLASS_O(cls), .FILE_ADDR_O(file_addr), .DEST_FILE_O(dest_file),
        .BANKED_O(banked), .BIT_NUM_O(bit_num), .LITERAL_O(literal), .PTR_SEL_O(ptr_sel),
        .FAST_MODE_O(fast_mode), .TBL_ACCESS_O(tbl_access), .TBL_MODE_O(tbl_mode),
        .BRANCH_OFF_O(branch_off), .SECOND_OPND_O(second_opnd), .EXT_OP_O(ext_op),
        .WR_ACC_O(wr_acc), .WR_FILE_O(wr_file));

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic final_report();
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(negedge core_clk);
        chk("reg_rdata", reg_rdata, exp);
        @(negedge core_clk);
        chk("reg_rdata_idle", reg_rdata, 32'h0000_0000);
    endtask

    // Observed and expected operand fields for each field kind
    function automatic logic [23:0] pick(input logic [3:0] k, input logic [15:0] w);
        case (k)
            4'h1: pick = {2'h0, dest_file, banked, file_addr, 2'h0, w[9:0]};
            4'h2: pick = {bit_num, banked, file_addr, w[11:0]};
            4'h3: pick = {4'h0, literal, 4'h0, w[7:0]};
            4'h4: pick = {11'h000, fast_mode, 11'h000, w[0]};
            4'h5: pick = {9'h000, tbl_access, tbl_mode, 9'h000, 1'h1, w[1:0]};
            4'h6: pick = {second_opnd, w[11:0]};
            4'h7: pick = {10'h000, ptr_sel, 10'h000, w[5:4]};
            4'h8: pick = {11'h000, ext_op, 12'h001};
            4'h9: pick = {1'h0, branch_off, 1'h0, w[10:0]};
            default: pick = 24'h00_0000;
        endcase
    endfunction

    task automatic run_entry(input int i);
        logic [15:0] w;
        logic [15:0] c;
        logic [23:0] pk;
        int n;
        w = WORDS[i];
        c = CODES[i];
        n = 0;
        @(negedge core_clk);
        while (advance !== 1'h1 && n < 16) begin
            @(negedge core_clk);
            n++;
        end
        chk("advance", 32'(advance), 32'h0000_0001);
        chk("q_phase", 32'(q_phase), 32'h0000_0000);
        if (i > 0) chk("advance_gap", 32'(cyc - last_adv), 32'h0000_0004);
        last_adv = cyc;
        chk("flush", 32'(flush), 32'(c[13]));
        @(negedge core_clk);
        chk("exec_state", 32'(exec_state), 32'(c[13:12]));
        if (c[13:12] == 2'h0) chk("class", 32'(cls), 32'(c[10:8]));
        chk("writes", 32'({wr_acc, wr_file}), 32'(c[5:4]));
        pk = pick(c[3:0], w);
        chk("fields", 32'(pk[23:12]), 32'(pk[11:0]));
    endtask

    initial begin
        core_clk = 1'h0;
        rst_n = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        errors = 0;
        checked = 0;
        cyc = 0;
        last_adv = 0;
        for (int i = 0; i < 64; i++) begin
            prog[i] = (i < N) ? WORDS[i % N] : 16'h0000;
            pcond[i] = (i < N) ? CODES[i % N][15] : 1'h0;
        end
        repeat (12) @(posedge core_clk);
        rst_n <= 1'h1;
        @(negedge core_clk);
        chk("reset_state", 32'(exec_state), 32'h0000_0002);
        for (int i = 0; i < N; i++) begin
            run_entry(i);
            if (i == 30) reg_write(`IWD_REG_CTRL, 32'h0000_0003);
        end
        reg_check(`IWD_REG_CTRL, 32'h0000_0003);
        reg_write(`IWD_REG_CTRL, 32'h0000_0000);
        repeat (2) @(negedge core_clk);
        stop_cnt = 0;
        repeat (12) begin
            @(negedge core_clk);
            if (advance === 1'h1) stop_cnt++;
        end
        chk("stopped_pulses", 32'(stop_cnt), 32'h0000_0000);
        reg_write(`IWD_REG_CYCLES, 32'h0000_0000);
        reg_check(`IWD_REG_CYCLES, 32'h0000_0000);
        reg_write(`IWD_REG_INSTRS, 32'h0000_0000);
        reg_check(`IWD_REG_INSTRS, 32'h0000_0000);
        reg_check(`IWD_REG_INFO, 32'h0000_084B);
        reg_write(`IWD_REG_INFO, 32'h0000_0000);
        reg_check(`IWD_REG_INFO, 32'h0000_084B);
        reg_check(4'hF, 32'h0000_0000);
        @(posedge core_clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'h1;
        reg_check(`IWD_REG_CTRL, 32'h0000_0001);
        final_report();
    end

    initial begin
        repeat (2000) @(posedge core_clk);
        errors++;
        final_report();
    end
endmodule // testbench
